// ### core/sbs_pkg.sv
// Package for the subtract-with-borrow and string scan datapath.
package sbs_pkg;

  localparam int SBS_WORD_W = 16;
  localparam int SBS_BYTE_W = 8;
  localparam logic [15:0] SBS_STEP_BYTE = 16'h0001;
  localparam logic [15:0] SBS_STEP_WORD = 16'h0002;
  localparam logic [15:0] SBS_ZERO_WORD = 16'h0000;
  localparam int SBS_RES_ZERO = 0;
  localparam int SBS_CX_ONE = 1;

  typedef enum logic [1:0] {
    SBS_OP_NONE = 2'h0,
    SBS_OP_SUB_BORROW = 2'h1,
    SBS_OP_SCAN = 2'h2
  } sbs_op_type;

  typedef enum logic [1:0] {
    SBS_REP_NONE = 2'h0,
    SBS_REP_EQUAL = 2'h1,
    SBS_REP_UNEQUAL = 2'h2
  } sbs_rep_type;

  typedef enum logic [1:0] {
    SBS_ST_IDLE = 2'h0,
    SBS_ST_SCAN = 2'h1
  } sbs_state_type;

  // Arithmetic flags; direction, interrupt-enable and trap live elsewhere.
  typedef struct packed {
    logic overflow_flag;
    logic sign_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic parity_flag;
    logic carry_flag;
  } sbs_flags_type;

  // One instruction request from the decoder and operand fetch.
  typedef struct packed {
    sbs_op_type op;
    logic word;
    sbs_rep_type rep;
    logic [15:0] dest;
    logic [15:0] src;
    logic [15:0] accumulator_word;
    logic [15:0] destination_index;
    logic [15:0] count_register;
    logic direction_flag;
  } sbs_req_type;

endpackage : sbs_pkg

// ### core/sbs_sub_unit.sv
// Byte or word subtractor with borrow in and full flag generation.
`timescale 1ns/1ps
`default_nettype none
module sbs_sub_unit (
  // Operands.
  input wire logic [15:0] a,
  input wire logic [15:0] b,
  input wire logic borrow_in,
  input wire logic word,
  // Results.
  output logic [15:0] diff,
  output sbs_pkg::sbs_flags_type flags
);
  import sbs_pkg::*;

  logic [16:0] full;
  logic [8:0] low;
  logic [4:0] nib;
  logic msb_a;
  logic msb_b;
  logic msb_d;

  always_comb begin
    full = {1'b0, a} - {1'b0, b} - {16'h0000, borrow_in};
    low = {1'b0, a[7:0]} - {1'b0, b[7:0]} - {8'h00, borrow_in};
    nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow_in};
    diff = word ? full[15:0] : {8'h00, low[7:0]};
    msb_a = word ? a[15] : a[7];
    msb_b = word ? b[15] : b[7];
    msb_d = word ? full[15] : low[7];
    flags.carry_flag = word ? full[16] : low[8];
    flags.aux_carry_flag = nib[4];
    flags.overflow_flag = (msb_a != msb_b) && (msb_d != msb_a);
    flags.sign_flag = msb_d;
    flags.zero_flag = (diff == SBS_ZERO_WORD);
    flags.parity_flag = ~^diff[7:0];
  end

endmodule : sbs_sub_unit
`default_nettype wire

// ### core/sbs_datapath.sv
// Execution datapath for subtract-with-borrow and repeated string scan.
// Contract
// - Subtract-with-borrow: dest minus src, minus one more if carry set.
// - Byte and word sizes; signed and unsigned treated identically.
// - Subtract-with-borrow updates six arithmetic flags, keeps DF, IF, TF.
// - Scan subtracts element from low accumulator byte or accumulator word.
// - Scan discards result, writes neither memory nor accumulator.
// - Each scan step moves destination index up if direction 0, else down.
// - Scan sets six arithmetic flags from compare, keeps DF, IF, TF.
// - Repeat-while-equal continues while count nonzero and zero flag 1.
// - Repeat-while-unequal continues while count nonzero and zero flag 0.
`timescale 1ns/1ps
`default_nettype none
module sbs_datapath (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Instruction request.
  input wire logic req_valid,
  input wire sbs_pkg::sbs_req_type req,
  input wire logic carry_in,
  // Element fetch during a scan.
  output logic elem_req,
  output logic [15:0] elem_addr,
  input wire logic elem_valid,
  input wire logic [15:0] elem_data,
  // Results.
  output logic busy,
  output logic done,
  output logic dest_we,
  output logic [15:0] dest_value,
  output logic flags_we,
  output sbs_pkg::sbs_flags_type flags,
  output logic [15:0] destination_index,
  output logic [15:0] count_register
);
  import sbs_pkg::*;

  typedef struct packed {
    sbs_state_type st;
    logic word;
    sbs_rep_type rep;
    logic dirn;
    logic [15:0] acc;
    logic elem_req;
    logic busy;
    logic done;
    logic dest_we;
    logic [15:0] dest_value;
    logic flags_we;
    sbs_flags_type flags;
    logic [15:0] di;
    logic [15:0] cx;
  } sbs_core_type;

  sbs_core_type s_r;
  sbs_core_type s_nxt;
  logic [15:0] sub_a;
  logic [15:0] sub_b;
  logic sub_bin;
  logic sub_word;
  logic [15:0] sub_diff;
  sbs_flags_type sub_flags;

  // Step size by element size.
  function automatic logic [15:0] step_of(input logic word);
    step_of = word ? SBS_STEP_WORD : SBS_STEP_BYTE;
  endfunction : step_of

  // Next index; direction 0 counts up.
  function automatic logic [15:0] next_index(input logic [15:0] di,
                                             input logic word,
                                             input logic dirn);
    next_index = dirn ? di - step_of(word) : di + step_of(word);
  endfunction : next_index

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    if (s_r.st == SBS_ST_SCAN) begin
      sub_a = s_r.word ? s_r.acc : {8'h00, s_r.acc[7:0]};
      sub_b = s_r.word ? elem_data : {8'h00, elem_data[7:0]};
      sub_bin = 1'b0;
      sub_word = s_r.word;
    end else begin
      sub_a = req.dest;
      sub_b = req.src;
      sub_bin = carry_in;
      sub_word = req.word;
    end
  end

  sbs_sub_unit u_sub (
    .a(sub_a),
    .b(sub_b),
    .borrow_in(sub_bin),
    .word(sub_word),
    .diff(sub_diff),
    .flags(sub_flags)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic go_on;
    logic [15:0] cx_dec;
    go_on = 1'b0;
    cx_dec = s_r.cx - 16'h0001;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.dest_we = 1'b0;
    s_nxt.flags_we = 1'b0;
    case (s_r.st)
      SBS_ST_IDLE: begin
        if (req_valid && req.op == SBS_OP_SUB_BORROW) begin
          s_nxt.dest_we = 1'b1;
          s_nxt.dest_value = sub_diff;
          s_nxt.flags_we = 1'b1;
          s_nxt.flags = sub_flags;
          s_nxt.done = 1'b1;
        end else if (req_valid && req.op == SBS_OP_SCAN) begin
          s_nxt.word = req.word;
          s_nxt.rep = req.rep;
          s_nxt.dirn = req.direction_flag;
          s_nxt.acc = req.accumulator_word;
          s_nxt.di = req.destination_index;
          s_nxt.cx = req.count_register;
          if (req.rep != SBS_REP_NONE && req.count_register == SBS_ZERO_WORD)
          begin
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.st = SBS_ST_SCAN;
            s_nxt.busy = 1'b1;
            s_nxt.elem_req = 1'b1;
          end
        end
      end
      SBS_ST_SCAN: begin
        if (elem_valid) begin
          // The difference is dropped; only flags, index and, under a repeat, count move.
          s_nxt.flags_we = 1'b1;
          s_nxt.flags = sub_flags;
          s_nxt.di = next_index(s_r.di, s_r.word, s_r.dirn);
          if (s_r.rep != SBS_REP_NONE) begin
            s_nxt.cx = cx_dec;
            if (s_r.rep == SBS_REP_EQUAL) begin
              go_on = (cx_dec != SBS_ZERO_WORD) && sub_flags.zero_flag;
            end else begin
              go_on = (cx_dec != SBS_ZERO_WORD) && !sub_flags.zero_flag;
            end
          end
          if (go_on) begin
            s_nxt.elem_req = 1'b1;
          end else begin
            s_nxt.st = SBS_ST_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.elem_req = 1'b0;
            s_nxt.done = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = SBS_ST_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.elem_req = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    elem_req = s_r.elem_req;
    elem_addr = s_r.di;
    busy = s_r.busy;
    done = s_r.done;
    dest_we = s_r.dest_we;
    dest_value = s_r.dest_value;
    flags_we = s_r.flags_we;
    flags = s_r.flags;
    destination_index = s_r.di;
    count_register = s_r.cx;
  end

  ////////////////////////////////////////////////////////////////////////////

  sequence sbb_issue;
    !busy && req_valid && req.op == SBS_OP_SUB_BORROW;
  endsequence

  sequence scan_step;
    busy && elem_valid;
  endsequence

  a_sbb_result: assert property (@(posedge clk) disable iff (!arst_n)
    sbb_issue |=> dest_we && dest_value == (($past(req.word) ?
      $past(req.dest) - $past(req.src) - {15'h0000, $past(carry_in)} :
      {8'h00, 8'($past(req.dest[7:0]) - $past(req.src[7:0])
      - {7'h00, $past(carry_in)})})))
    else $error("subtract with borrow result wrong");

  a_sbb_byte_zero: assert property (@(posedge clk) disable iff (!arst_n)
    sbb_issue and (!req.word) |=> dest_value[15:8] == 8'h00)
    else $error("byte subtract left upper byte set");

  a_sbb_flags: assert property (@(posedge clk) disable iff (!arst_n)
    sbb_issue |=> flags_we && done &&
      flags.zero_flag == (dest_value == SBS_ZERO_WORD))
    else $error("subtract flags not written");

  a_scan_no_write: assert property (@(posedge clk) disable iff (!arst_n)
    busy |-> !dest_we)
    else $error("scan wrote destination");

  a_scan_index: assert property (@(posedge clk) disable iff (!arst_n)
    scan_step |=> destination_index == $past(destination_index) +
      ($past(s_r.dirn) ? -step_of($past(s_r.word)) : step_of($past(s_r.word))))
    else $error("destination index step wrong");

  a_scan_flags: assert property (@(posedge clk) disable iff (!arst_n)
    scan_step |=> flags_we && flags.zero_flag == ($past(s_r.word) ?
      $past(s_r.acc) == $past(elem_data) :
      $past(s_r.acc[7:0]) == $past(elem_data[7:0])))
    else $error("scan flags wrong");

  a_rep_equal_stop: assert property (@(posedge clk) disable iff (!arst_n)
    scan_step and (s_r.rep == SBS_REP_EQUAL && !sub_flags.zero_flag) |=>
      !busy && done)
    else $error("equal repeat did not stop on mismatch");

  a_rep_unequal: assert property (@(posedge clk) disable iff (!arst_n)
    scan_step and (s_r.rep == SBS_REP_UNEQUAL && !sub_flags.zero_flag &&
      count_register > 16'(SBS_CX_ONE)) |=> busy)
    else $error("unequal repeat stopped early");

  a_count_dec: assert property (@(posedge clk) disable iff (!arst_n)
    scan_step and (s_r.rep != SBS_REP_NONE) |=>
      count_register == $past(count_register) - 16'h0001)
    else $error("count not decremented");

endmodule : sbs_datapath
`default_nettype wire

// ### verification/sbs_elem_model.sv
// Element memory model that answers the scan datapath's string fetches.
`timescale 1ns/1ps
`default_nettype none
module sbs_elem_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Element fetch.
  input wire logic elem_req,
  input wire logic [15:0] elem_addr,
  output logic elem_valid,
  output logic [15:0] elem_data,
  // Answer delay in cycles.
  input wire logic [3:0] wait_cycles
);
  logic [15:0] mem [16];
  logic [3:0] cnt_r;
  // Between answers the data flips each cycle so stale data cannot pass.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      elem_valid <= 1'b0;
      elem_data <= 16'h0000;
      cnt_r <= 4'h0;
    end else if (!elem_valid && elem_req && cnt_r == wait_cycles) begin
      elem_valid <= 1'b1;
      elem_data <= mem[elem_addr[3:0]];
      cnt_r <= 4'h0;
    end else begin
      elem_valid <= 1'b0;
      elem_data <= ~elem_data;
      cnt_r <= (elem_req && !elem_valid) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule : sbs_elem_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the subtract and string scan datapath.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sbs_pkg::*;
  logic clk, arst_n, req_valid, carry_in, elem_req, elem_valid;
  logic busy, done, dest_we, flags_we;
  logic [15:0] elem_addr, elem_data, dest_value, destination_index;
  logic [15:0] count_register;
  logic [3:0] wait_cycles;
  sbs_req_type req;
  sbs_flags_type flags;
  int n_errors;
  int samples_checked;

  sbs_datapath i_dut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
    .req(req), .carry_in(carry_in), .elem_req(elem_req),
    .elem_addr(elem_addr), .elem_valid(elem_valid), .elem_data(elem_data),
    .busy(busy), .done(done), .dest_we(dest_we), .dest_value(dest_value),
    .flags_we(flags_we), .flags(flags),
    .destination_index(destination_index),
    .count_register(count_register));
  sbs_elem_model i_mem (.clk(clk), .arst_n(arst_n), .elem_req(elem_req),
    .elem_addr(elem_addr), .elem_valid(elem_valid), .elem_data(elem_data),
    .wait_cycles(wait_cycles));

  task automatic finish_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_flags(input sbs_flags_type got,
      input sbs_flags_type exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_flags

  function automatic sbs_flags_type ref_sub(input logic [15:0] a,
      input logic [15:0] b, input logic c, input logic w,
      output logic [15:0] d);
    logic [16:0] f;
    logic [4:0] h;
    logic sa, sb, sr;
    f = {1'b0, w ? a : {8'h00, a[7:0]}} - {1'b0, w ? b : {8'h00, b[7:0]}}
      - {16'h0000, c};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
    d = w ? f[15:0] : {8'h00, f[7:0]};
    sa = w ? a[15] : a[7];
    sb = w ? b[15] : b[7];
    sr = w ? d[15] : d[7];
    return {(sa != sb) && (sr != sa), sr, d == 16'h0000, h[4], ~^d[7:0],
      f[16]};
  endfunction : ref_sub

  task automatic issue(input sbs_req_type r);
    @(negedge clk);
    req = r;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
  endtask : issue

  task automatic t_sub(input logic w, input logic [15:0] a,
      input logic [15:0] b, input logic c);
    sbs_req_type r;
    sbs_flags_type f;
    logic [15:0] d;
    r = '0;
    r.op = SBS_OP_SUB_BORROW;
    r.word = w;
    r.dest = a;
    r.src = b;
    carry_in = c;
    f = ref_sub(a, b, c, w, d);
    issue(r);
    check_val({15'h0, dest_we & flags_we & done}, 16'h0001);
    check_val(dest_value, d);
    check_flags(flags, f);
  endtask : t_sub

  task automatic t_scan(input logic w, input sbs_rep_type rep,
      input logic [15:0] acc, input logic [15:0] di, input logic [15:0] cx,
      input logic dirn);
    sbs_req_type r;
    sbs_flags_type f, got;
    logic [15:0] d, idx, cnt, e, stp;
    int steps, seen;
    logic wr, go, run;
    r = '0;
    r.op = SBS_OP_SCAN;
    r.word = w;
    r.rep = rep;
    r.accumulator_word = acc;
    r.destination_index = di;
    r.count_register = cx;
    r.direction_flag = dirn;
    carry_in = 1'b1;
    stp = w ? 16'h0002 : 16'h0001;
    idx = di;
    cnt = cx;
    steps = 0;
    go = !(rep != SBS_REP_NONE && cx == 16'h0000);
    run = go;
    while (go) begin
      f = ref_sub(acc, i_mem.mem[idx[3:0]], 1'b0, w, d);
      idx = dirn ? idx - stp : idx + stp;
      steps++;
      cnt = (rep == SBS_REP_NONE) ? cnt : cnt - 16'h0001;
      go = rep != SBS_REP_NONE && cnt != 16'h0000
        && f.zero_flag == (rep == SBS_REP_EQUAL);
    end
    e = di;
    seen = 0;
    wr = 1'b0;
    issue(r);
    check_val({14'h0, busy, elem_req}, run ? 16'h0003 : 16'h0000);
    repeat (200) begin
      if (elem_valid === 1'b1) begin
        check_val(elem_addr, e);
        e = dirn ? e - stp : e + stp;
      end
      wr = wr | dest_we;
      if (flags_we === 1'b1) begin
        seen++;
        got = flags;
      end
      if (done === 1'b1) break;
      @(negedge clk);
    end
    check_val({15'h0, done}, 16'h0001);
    check_val({14'h0, busy, elem_req}, 16'h0000);
    check_val(16'(seen), 16'(steps));
    check_val({15'h0, wr}, 16'h0000);
    if (steps > 0) begin
      check_flags(got, f);
      check_val(destination_index, idx);
      check_val(count_register, cnt);
    end
  endtask : t_scan

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #50000;
    n_errors++;
    finish_test();
  end

  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    carry_in = 1'b0;
    wait_cycles = 4'h0;
    n_errors = 0;
    samples_checked = 0;
    for (int i = 0; i < 16; i++) begin
      i_mem.mem[i] = (i >= 2 && i <= 5) ? 16'h0041 :
        (i == 6) ? 16'h0042 : 16'h8000 + 16'(i);
    end
    repeat (10) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    t_sub(1'b0, 16'h0000, 16'h0001, 1'b0);
    t_sub(1'b0, 16'h0080, 16'h0001, 1'b1);
    t_sub(1'b1, 16'h8000, 16'h0001, 1'b0);
    t_sub(1'b1, 16'h1234, 16'h1234, 1'b1);
    t_sub(1'b1, 16'h0005, 16'h0004, 1'b1);
    t_sub(1'b0, 16'hff10, 16'hee10, 1'b0);
    t_scan(1'b0, SBS_REP_NONE, 16'hff41, 16'h0002, 16'h0007, 1'b1);
    t_scan(1'b1, SBS_REP_NONE, 16'h0041, 16'h0007, 16'h0007, 1'b0);
    t_scan(1'b0, SBS_REP_EQUAL, 16'h0041, 16'h0002, 16'h0008, 1'b0);
    t_scan(1'b0, SBS_REP_EQUAL, 16'h0041, 16'h0002, 16'h0002, 1'b0);
    wait_cycles = 4'h3;
    t_scan(1'b0, SBS_REP_UNEQUAL, 16'h0042, 16'h0002, 16'h0009, 1'b0);
    t_scan(1'b1, SBS_REP_EQUAL, 16'h0041, 16'h0005, 16'h0008, 1'b1);
    t_scan(1'b1, SBS_REP_UNEQUAL, 16'h0041, 16'h0005, 16'h0000, 1'b0);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
